// File: bench/ssp_host.sv
// host cpu model: master of the serial link to the device
module ssp_host
(
  input  wire logic i_clock,  // system clock
  output logic      o_sck,    // serial clock pin
  output logic      o_cs_n,   // select pin, low
  output logic      o_sdi,    // data toward the device
  input  wire logic i_sdo     // level of the answer pin
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] tx [80];
  logic [7:0] rx [80];

  // idle levels: clock rests low between frames, except during sel_pulse
  initial
  begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b1;
    foreach (tx[i])
      tx[i] = 8'h00;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // ==========================================================
  // frame of n bytes; four clocks a level keeps data far from edges
  task automatic frame(input int n);
    logic [7:0] sh;
    wait_clk(1);
    o_cs_n <= 1'b0;
    for (int b = 0; b < n; b++)
    begin
      for (int i = 7; i >= 0; i--)
      begin
        o_sdi <= tx[b][i];
        wait_clk(4);
        o_sck <= 1'b1;
        wait_clk(4);
        sh[i] = i_sdo;
        o_sck <= 1'b0;
      end
      rx[b] = sh;
    end
    wait_clk(4);
    o_sdi  <= ~o_sdi;                   // stale data never left standing
    o_cs_n <= 1'b1;
    wait_clk(6);
  endtask

  // one clock pulse with select high, to switch between devices
  task automatic sel_pulse();
    o_sck <= 1'b1;
    wait_clk(4);
    o_sck <= 1'b0;
    wait_clk(4);
  endtask
endmodule

// File: bench/tb.sv
// testbench: link frames, write stream, pass mode, pin roles
`include "ssp_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        i_clock     = 1'b0;
  logic        i_srst      = 1'b1;
  logic        sck;
  logic        cs_n;
  logic        host_sdi;
  logic        sdi_wire;
  logic        do_wire;
  logic        o_serial_in;
  logic        o_serial_in_oe;
  logic        o_do;
  logic        o_do_oe;
  logic        msel_n;
  logic        pass;
  logic        sa_rx;
  logic [1:0]  unit_id     = 2'b10;
  logic        standalone  = 1'b0;
  logic        sa_tx       = 1'b0;
  logic        sa_level    = 1'b0;
  logic        sa_do       = 1'b0;
  logic [31:0] main_status = 32'h1234_5678;
  logic [15:0] speed       = 16'h9ABC;
  logic        wr_valid;
  logic        wr_ready    = 1'b1;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [15:0] wq [$];
  int          err_total   = 0;
  int          checks_done = 0;
  int          oe_hits     = 0;
  int          msel_hits   = 0;

  always #50 i_clock = ~i_clock;

  // pin levels from every party's enable
  assign sdi_wire = o_serial_in_oe ? o_serial_in : host_sdi;
  assign do_wire  = o_do_oe ? o_do : sa_do;

  ssp_host host (
    .i_clock (i_clock),
    .o_sck   (sck),
    .o_cs_n  (cs_n),
    .o_sdi   (host_sdi),
    .i_sdo   (do_wire)
  );

  ssp_top uut (
    .i_clock               (i_clock),
    .i_srst                (i_srst),
    .i_sck                 (sck),
    .i_cs_n                (cs_n),
    .i_serial_in           (sdi_wire),
    .o_serial_in           (o_serial_in),
    .o_serial_in_oe        (o_serial_in_oe),
    .i_do                  (do_wire),
    .o_do                  (o_do),
    .o_do_oe               (o_do_oe),
    .o_memory_select_out_n (msel_n),
    .i_unit_id_bit0        (unit_id[0]),
    .i_unit_id_bit1        (unit_id[1]),
    .i_standalone          (standalone),
    .i_sa_tx               (sa_tx),
    .o_sa_rx               (sa_rx),
    .i_main_status         (main_status),
    .i_current_speed       (speed),
    .o_wr_valid            (wr_valid),
    .o_wr_addr             (wr_addr),
    .o_wr_data             (wr_data),
    .i_wr_ready            (wr_ready),
    .o_pass_mode           (pass)
  );

  // undriven answer pin toggles, so a stale level never matches
  always @(posedge i_clock)
    sa_do <= standalone ? sa_level : ~sa_do;

  // collect taken writes, count answer and memory select activity
  always @(posedge i_clock)
  begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      wq.push_back({wr_addr, wr_data});
    if (o_do_oe === 1'b1)
      oe_hits++;
    // select is unknown before the first reset edge; skip reset cycles
    if (i_srst === 1'b0 && msel_n !== 1'b1)
      msel_hits++;
  end

  // ==========================================================
  // compare and verdict tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_wr(input logic [15:0] exp);
    logic [15:0] w;
    w = (wq.size() > 0) ? wq.pop_front() : 16'hXXXX;
    chk8(w[15:8], exp[15:8]);
    chk8(w[7:0], exp[7:0]);
  endtask

  task automatic close_out();
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // first eight bytes of a frame, then n bytes on the link
  task automatic send(input logic [63:0] v, input int n);
    for (int i = 0; i < 8; i++)
      host.tx[i] = v[63 - 8*i -: 8];
    host.frame(n);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge i_clock);
    i_srst <= 1'b0;
    repeat (4) @(posedge i_clock);
    chk1(msel_n, 1'b1);
    chk1(pass, 1'b0);
    chk1(wr_valid, 1'b0);
    // burst write with consumer stalled; nothing may be lost
    wr_ready <= 1'b0;
    send({8'h22, 8'h22, 8'h5A, 8'hA5, 8'h3C, 24'h0}, 5);
    chk1(wr_valid, 1'b1);
    chk1(wq.size() == 0, 1'b1);
    wr_ready <= 1'b1;
    repeat (8) @(posedge i_clock);
    chk_wr(16'h225A);
    chk_wr(16'h23A5);
    chk_wr(16'h243C);
    chk1(wq.size() == 0, 1'b1);
    // read back, write-only byte reads zero
    send({8'h23, 8'h22, 48'h0}, 6);
    chk8(host.rx[2], 8'h5A);
    chk8(host.rx[3], 8'hA5);
    chk8(host.rx[4], 8'h3C);
    chk8(host.rx[5], 8'h00);
    chk1(oe_hits > 0, 1'b1);
    // long read across the 64 byte wrap
    send({8'h23, 8'h26, 48'h0}, 67);
    for (int k = 0; k < 4; k++)
      chk8(host.rx[2 + k], main_status[31 - 8*k -: 8]);
    chk8(host.rx[18], speed[15:8]);
    chk8(host.rx[19], speed[7:0]);
    chk8(host.rx[20], 8'h00);
    chk8(host.rx[28], 8'h00);
    chk8(host.rx[66], main_status[31:24]);
    // write wraps FF to 00; only 04 is defined and writable (37 is read-only)
    send({8'h22, 8'hFF, 48'h11_2233_4455_66}, 8);
    send({8'h22, 8'h37, 8'h01, 8'h02, 32'h0}, 4);
    chk_wr(16'h0466);
    chk1(wq.size() == 0, 1'b1);
    // status read and unit number match for every unit
    for (int u = 0; u < 4; u++)
    begin
      unit_id <= u[1:0];
      host.sel_pulse();
      send({2'b00, u[1:0], 4'h5, 56'h0}, 3);
      chk8(host.rx[1], `SSP_STATUS_BYTE);
      chk8(host.rx[2], `SSP_STATUS_BYTE);
      oe_hits = 0;
      send({2'b00, ~u[1:0], 4'h3, 8'h22, 48'h0}, 4);
      chk1(oe_hits == 0, 1'b1);
    end
    unit_id <= 2'b10;
    send({8'h12, 8'h22, 8'h77, 40'h0}, 3);
    chk1(wq.size() == 0, 1'b1);
    chk1(msel_hits == 0, 1'b1);
    // pass-through: select copied, commands other than pass-off ignored
    send({8'h26, 56'h0}, 1);
    chk1(pass, 1'b1);
    oe_hits = 0;
    send({8'h23, 8'h00, 8'h22, 40'h0}, 5);
    chk1(msel_hits > 0, 1'b1);
    chk1(msel_n, 1'b1);
    chk1(oe_hits == 0, 1'b1);
    send({8'h22, 8'h22, 8'h99, 40'h0}, 3);
    chk1(wq.size() == 0, 1'b1);
    send({8'h24, 56'h0}, 1);
    chk1(pass, 1'b0);
    chk1(msel_n, 1'b1);
    send({8'h23, 8'h22, 48'h0}, 3);
    chk8(host.rx[2], 8'h5A);
    // stand-alone swaps the roles of the two data pins
    standalone <= 1'b1;
    sa_tx      <= 1'b1;
    sa_level   <= 1'b1;
    repeat (5) @(posedge i_clock);
    chk1(o_serial_in_oe, 1'b1);
    chk1(o_serial_in, 1'b1);
    chk1(sa_rx, 1'b1);
    sa_tx    <= 1'b0;
    sa_level <= 1'b0;
    repeat (5) @(posedge i_clock);
    chk1(o_serial_in, 1'b0);
    chk1(sa_rx, 1'b0);
    standalone <= 1'b0;
    repeat (5) @(posedge i_clock);
    chk1(o_serial_in_oe, 1'b0);
    close_out();
  end

  // cut a hang short, well past the expected run length
  initial
  begin
    repeat (20000) @(posedge i_clock);
    err_total++;
    close_out();
  end
endmodule

// File: verilog/ssp_pkg.sv
// types shared by the serial slave port modules
package ssp_pkg;

  // link decoder states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_RADDR,
    ST_WADDR,
    ST_WDATA,
    ST_RDATA,
    ST_STAT,
    ST_SKIP
  } ssp_state_t;

  // one register write on its way to the register file
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } ssp_wr_t;

endpackage

// File: verilog/ssp_regs.svh
// constants of the serial slave port: codes, offsets, reset values
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

// ==========================================================
// bus control command fields
`define SSP_CMD_HI        2'h0
`define SSP_OP_READ       4'h3
`define SSP_OP_WRITE      4'h2
`define SSP_OP_STATUS     4'h5
`define SSP_OP_PASS_ON    4'h6
`define SSP_OP_PASS_OFF   4'h4
`define SSP_STATUS_BYTE   8'h70

// ==========================================================
// register byte offsets (6-bit read space)
`define SSP_OFS_MODE_LOW  6'h22
`define SSP_OFS_MODE      6'h23
`define SSP_OFS_CMD_ENTRY 6'h25
`define SSP_OFS_STATUS    6'h26
`define SSP_OFS_INT_CAUSE 6'h2A
`define SSP_OFS_GPIO_CTL  6'h2C
`define SSP_OFS_POS_CNT   6'h2E
`define SSP_OFS_WORK_CNT  6'h32
`define SSP_OFS_SPEED     6'h36
`define SSP_UNDEF_LO_LAST 6'h03
`define SSP_UNDEF_HI_FIRST 6'h38

// ==========================================================
// reset values
`define SSP_PIN_RST       7'h40
`define SSP_REG_RST       8'h00

`endif

// File: verilog/ssp_top.sv
// serial slave port: command decode, register access, memory pass
`include "ssp_regs.svh"
// ==========================================================
module ssp_top
  import ssp_pkg::*;
(
  input  wire logic        i_clock,         // 10 MHz system clock
  input  wire logic        i_srst,          // sync reset, high
  input  wire logic        i_sck,           // serial clock pin
  input  wire logic        i_cs_n,          // host select, low
  input  wire logic        i_serial_in,     // serial input pin level
  output logic             o_serial_in,     // serial input pin drive
  output logic             o_serial_in_oe,  // serial input pin enable
  input  wire logic        i_do,            // serial output pin level
  output logic             o_do,            // serial output pin drive
  output logic             o_do_oe,         // serial output pin enable
  output logic             o_memory_select_out_n, // memory select
  input  wire logic        i_unit_id_bit0,  // unit number pin 0
  input  wire logic        i_unit_id_bit1,  // unit number pin 1
  input  wire logic        i_standalone,    // stand-alone mode pin
  input  wire logic        i_sa_tx,         // stand-alone data out
  output logic             o_sa_rx,         // stand-alone data in
  input  wire logic [31:0] i_main_status,   // status word
  input  wire logic [15:0] i_current_speed, // speed word
  output logic             o_wr_valid,      // register write valid
  output logic [7:0]       o_wr_addr,       // register write address
  output logic [7:0]       o_wr_data,       // register write byte
  input  wire logic        i_wr_ready,      // register write taken
  output logic             o_pass_mode      // pass-through active
);

  // ==========================================================
  // declarations
  logic [6:0]  pin_m_r;
  logic [6:0]  pin_s_r;
  logic        sck_d_r;
  logic        cs_d_r;
  logic        sa_tx_r;
  ssp_state_t  st_r;
  ssp_state_t  st_nxt;
  logic [2:0]  bit_r;
  logic [7:0]  rx_r;
  logic        pass_r;
  logic        enter_r;
  logic        mem_sel_n_r;
  logic [5:0]  rd_addr_r;
  logic [7:0]  wr_addr_r;
  logic [7:0]  tx_r;
  logic [2:0]  tx_cnt_r;
  logic        do_r;
  logic        do_oe_r;
  logic        pend_r;
  ssp_wr_t     pend_d_r;
  logic [7:0]  mem_r [0:63];
  wire         cs_s;
  wire         sck_s;
  wire         sin_s;
  wire         do_s;
  wire  [1:0]  id_s;
  wire         mode_s;
  wire         frame;
  wire         sck_rise;
  wire         sck_fall;
  wire         cs_fall;
  wire         cs_rise;
  wire  [7:0]  rx_nxt;
  wire         byte_done;
  wire         cmd_ok;
  wire  [3:0]  cmd_op;
  wire         at_cmd;
  wire         cmd_exit;
  wire         cmd_enter;
  ssp_state_t  cmd_dest;
  wire  [5:0]  rd_idx;
  wire  [7:0]  rd_val;
  wire         tx_act;
  wire         tx_last;
  wire         wr_take;
  wire         pop;

  ssp_wr_if fill_if ();
  ssp_wr_if drain_if ();

  // ==========================================================
  // decode helpers
  function automatic logic unit_match(input logic [7:0] c,
                                      input logic [1:0] id);
    unit_match = (c[7:6] == `SSP_CMD_HI) && (c[5:4] == id);
  endfunction

  function automatic logic addr_defined(input logic [5:0] a);
    addr_defined = (a > `SSP_UNDEF_LO_LAST) &&
                   (a < `SSP_UNDEF_HI_FIRST);
  endfunction

  function automatic logic addr_ro(input logic [5:0] a);
    addr_ro = ((a >= `SSP_OFS_STATUS) && (a < `SSP_OFS_INT_CAUSE)) ||
              (a >= `SSP_OFS_SPEED);
  endfunction

  function automatic logic [7:0] read_byte(input logic [5:0]  a,
                                           input logic [7:0]  m,
                                           input logic [31:0] s,
                                           input logic [15:0] v);
    logic [7:0] r;
    r = m;
    unique case (a)
      `SSP_OFS_CMD_ENTRY:      r = `SSP_REG_RST;
      `SSP_OFS_STATUS:         r = s[31:24];
      `SSP_OFS_STATUS + 6'h1:  r = s[23:16];
      `SSP_OFS_STATUS + 6'h2:  r = s[15:8];
      `SSP_OFS_STATUS + 6'h3:  r = s[7:0];
      `SSP_OFS_SPEED:          r = v[15:8];
      `SSP_OFS_SPEED + 6'h1:   r = v[7:0];
      default:                 r = m;
    endcase
    if (!addr_defined(a))
      r = 8'h00;
    read_byte = r;
  endfunction

  function automatic ssp_state_t cmd_target(input logic [3:0] op,
                                            input logic       ok,
                                            input logic       pass);
    ssp_state_t t;
    t = ST_SKIP;
    if (ok && !pass)
    begin
      if (op == `SSP_OP_READ)
        t = ST_RADDR;
      else if (op == `SSP_OP_WRITE)
        t = ST_WADDR;
      else if (op == `SSP_OP_STATUS)
        t = ST_STAT;
    end
    cmd_target = t;
  endfunction

  // ==========================================================
  // pin synchronisers: {cs, sck, sin, do, id1, id0, mode}
  // the link clock is only sampled, so it needs 8+ clocks per period
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      pin_m_r <= `SSP_PIN_RST;
      pin_s_r <= `SSP_PIN_RST;
      sck_d_r <= 1'b0;
      cs_d_r  <= 1'b1;
      sa_tx_r <= 1'b0;
    end
    else
    begin
      pin_m_r <= {i_cs_n, i_sck, i_serial_in, i_do,
                  i_unit_id_bit1, i_unit_id_bit0, i_standalone};
      pin_s_r <= pin_m_r;
      sck_d_r <= sck_s;
      cs_d_r  <= cs_s;
      sa_tx_r <= i_sa_tx;
    end
  end

  assign cs_s   = pin_s_r[6];
  assign sck_s  = pin_s_r[5];
  assign sin_s  = pin_s_r[4];
  assign do_s   = pin_s_r[3];
  assign id_s   = pin_s_r[2:1];
  assign mode_s = pin_s_r[0];

  // ==========================================================
  // frame and edge detection
  assign frame     = !cs_s;
  assign cs_fall   = !cs_s && cs_d_r;
  assign cs_rise   = cs_s && !cs_d_r;
  assign sck_rise  = frame && sck_s && !sck_d_r;
  assign sck_fall  = frame && !sck_s && sck_d_r;
  assign rx_nxt    = {rx_r[6:0], sin_s};
  assign byte_done = sck_rise && (bit_r == 3'h7);
  assign cmd_ok    = unit_match(rx_nxt, id_s);
  assign cmd_op    = rx_nxt[3:0];
  assign at_cmd    = byte_done && (st_r == ST_CMD);
  assign cmd_exit  = at_cmd && cmd_ok &&
                     (cmd_op == `SSP_OP_PASS_OFF);
  assign cmd_enter = at_cmd && cmd_ok && !pass_r &&
                     (cmd_op == `SSP_OP_PASS_ON);
  assign cmd_dest  = cmd_target(cmd_op, cmd_ok, pass_r);

  // bit counter and receive shifter
  always_ff @(posedge i_clock)
  begin
    if (i_srst || cs_fall)
      bit_r <= 3'h0;
    else if (sck_rise)
      bit_r <= bit_r + 3'h1;
    if (sck_rise)
      rx_r <= rx_nxt;
  end

  // ==========================================================
  // transaction sequencer
  always_comb
  begin
    st_nxt = st_r;
    if (cs_rise)
      st_nxt = ST_IDLE;
    else if (cs_fall)
      st_nxt = ST_CMD;
    else if (byte_done)
    begin
      unique case (st_r)
        ST_CMD:   st_nxt = cmd_dest;
        ST_RADDR: st_nxt = ST_RDATA;
        ST_WADDR: st_nxt = ST_WDATA;
        ST_IDLE, ST_WDATA, ST_RDATA, ST_STAT, ST_SKIP:
          st_nxt = st_r;
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      st_r <= ST_IDLE;
    else
      st_r <= st_nxt;
  end

  // ==========================================================
  // pass-through mode; entry waits for the select to rise so the
  // memory never sees the tail of the entry frame
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      pass_r  <= 1'b0;
      enter_r <= 1'b0;
    end
    else if (cs_rise)
    begin
      pass_r  <= pass_r | enter_r;
      enter_r <= 1'b0;
    end
    else if (cmd_exit)
    begin
      pass_r  <= 1'b0;
      enter_r <= 1'b0;
    end
    else if (cmd_enter)
      enter_r <= 1'b1;
  end

  // memory select copies the host select only in pass mode
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      mem_sel_n_r <= 1'b1;
    else
      mem_sel_n_r <= pass_r ? cs_s : 1'b1;
  end

  // ==========================================================
  // read path: data and status leave on falling edges
  assign rd_idx  = (st_r == ST_RADDR) ? rx_nxt[5:0]
                                      : rd_addr_r + 6'h01;
  assign rd_val  = read_byte(rd_idx, mem_r[rd_idx],
                             i_main_status, i_current_speed);
  assign tx_act  = (st_r == ST_RDATA) || (st_r == ST_STAT);
  assign tx_last = (tx_cnt_r == 3'h7);

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      rd_addr_r <= 6'h00;
      tx_r      <= 8'h00;
      tx_cnt_r  <= 3'h0;
      do_r      <= 1'b0;
    end
    else if (byte_done && (st_r == ST_RADDR))
    begin
      rd_addr_r <= rx_nxt[5:0];
      tx_r      <= rd_val;
      tx_cnt_r  <= 3'h0;
    end
    else if (at_cmd && (cmd_dest == ST_STAT))
    begin
      tx_r     <= `SSP_STATUS_BYTE;
      tx_cnt_r <= 3'h0;
    end
    else if (sck_fall && tx_act)
    begin
      do_r     <= tx_r[7];
      tx_cnt_r <= tx_cnt_r + 3'h1;
      if (!tx_last)
        tx_r <= {tx_r[6:0], 1'b0};
      else if (st_r == ST_RDATA)
        tx_r <= rd_val;
      else
        tx_r <= `SSP_STATUS_BYTE;
      if (tx_last && (st_r == ST_RDATA))
        rd_addr_r <= rd_addr_r + 6'h01;
    end
  end

  // output pin drive: only while this unit answers a host read
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      do_oe_r <= 1'b0;
    else
      do_oe_r <= frame && tx_act && !pass_r && !mode_s;
  end

  // ==========================================================
  // write path: address counter and one pending byte
  assign wr_take = byte_done && (st_r == ST_WDATA) &&
                   (wr_addr_r[7:6] == 2'h0) &&
                   addr_defined(wr_addr_r[5:0]) &&
                   !addr_ro(wr_addr_r[5:0]);

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      wr_addr_r <= 8'h00;
    else if (byte_done && (st_r == ST_WADDR))
      wr_addr_r <= rx_nxt;
    else if (byte_done && (st_r == ST_WDATA))
      wr_addr_r <= wr_addr_r + 8'h01;
  end

  // a byte lasts 64 clocks, so the buffer drains long before overrun
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      pend_r <= 1'b0;
    else if (wr_take)
      pend_r <= 1'b1;
    else if (fill_if.ready)
      pend_r <= 1'b0;
    if (wr_take)
      pend_d_r <= '{addr: wr_addr_r, data: rx_nxt};
  end

  assign fill_if.valid  = pend_r;
  assign fill_if.data   = pend_d_r;
  assign drain_if.ready = i_wr_ready;
  assign pop            = drain_if.valid && i_wr_ready;

  ssp_wr_buf u_buf (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .fill    (fill_if),
    .drain   (drain_if)
  );

  // register file takes each write as it leaves the buffer
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      for (int i = 0; i < 64; i++)
        mem_r[i] <= `SSP_REG_RST;
    end
    else if (pop)
      mem_r[drain_if.data.addr[5:0]] <= drain_if.data.data;
  end

  // ==========================================================
  // outputs
  assign o_serial_in           = sa_tx_r;
  assign o_serial_in_oe        = mode_s;
  assign o_sa_rx               = do_s;
  assign o_do                  = do_r;
  assign o_do_oe               = do_oe_r;
  assign o_memory_select_out_n = mem_sel_n_r;
  assign o_wr_valid            = drain_if.valid;
  assign o_wr_addr             = drain_if.data.addr;
  assign o_wr_data             = drain_if.data.data;
  assign o_pass_mode           = pass_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);

  a_sel_idle_high: assert property (
    !pass_r |=> o_memory_select_out_n)
    else $error("memory select low outside pass mode");
  a_pass_on_rise: assert property (
    $rose(pass_r) |-> cs_s && $past(enter_r))
    else $error("pass mode entered inside a frame");
  a_exit_forces: assert property (
    cmd_exit |=> !pass_r ##1 o_memory_select_out_n)
    else $error("exit did not release memory select");
  a_pass_ignore: assert property (
    at_cmd && pass_r |=> st_r == ST_SKIP)
    else $error("command obeyed in pass mode");
  a_undef_zero: assert property (
    !addr_defined(rd_idx) |-> rd_val == 8'h00)
    else $error("undefined address read non-zero");
  a_write_defined: assert property (
    wr_take |-> addr_defined(wr_addr_r[5:0]) && !addr_ro(wr_addr_r[5:0]))
    else $error("write accepted at undefined address");
  a_rd_wrap: assert property (
    sck_fall && tx_last && (st_r == ST_RDATA) && !byte_done
    |=> rd_addr_r == $past(rd_addr_r) + 6'h01)
    else $error("read address did not advance");
  a_wr_advance: assert property (
    byte_done && (st_r == ST_WDATA) |=> wr_addr_r == $past(wr_addr_r) + 8'h01)
    else $error("write address did not advance");
  a_status_load: assert property (
    at_cmd && (cmd_dest == ST_STAT) |=> tx_r == `SSP_STATUS_BYTE)
    else $error("status byte not loaded");
  a_do_on_fall: assert property (
    $changed(o_do) |-> $past(sck_fall))
    else $error("serial output changed off a falling edge");
endmodule

// File: verilog/ssp_wr_buf.sv
// two-entry buffer for register writes
module ssp_wr_buf
  import ssp_pkg::*;
(
  input  wire logic i_clock,  // system clock
  input  wire logic i_srst,   // synchronous reset, high
  ssp_wr_if.dst     fill,     // writes from the decoder
  ssp_wr_if.src     drain     // writes to the register file
);

  ssp_wr_t    mem_r [0:1];
  logic       wp_r;
  logic       rp_r;
  logic [1:0] cnt_r;
  wire        push;
  wire        pop;

  // ==========================================================
  // handshakes; full and empty follow the count
  assign fill.ready  = (cnt_r != 2'h2);
  assign drain.valid = (cnt_r != 2'h0);
  assign drain.data  = mem_r[rp_r];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  // storage has no reset; only counted entries are ever read
  always_ff @(posedge i_clock)
  begin
    if (push)
      mem_r[wp_r] <= fill.data;
  end

  // pointers and fill count
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      wp_r  <= wp_r ^ push;
      rp_r  <= rp_r ^ pop;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  a_buf_bounds: assert property (@(posedge i_clock) disable iff (i_srst)
    cnt_r != 2'h3)
    else $error("write buffer count out of range");
endmodule

// File: verilog/ssp_wr_if.sv
// carrier for the register write stream, decoder to buffer and buffer to register file
interface ssp_wr_if
  import ssp_pkg::*;
();
  logic    valid;
  logic    ready;
  ssp_wr_t data;

  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface
